// ### hdl/isc_pkg.sv
// Package: indexes, field positions, reset values and timing counts for the slot bus cycle control
package isc_pkg;
    // Indexed configuration port
    localparam logic [7:0] IDX_BUS_CONFIG_ONE = 8'h16;
    localparam logic [7:0] IDX_BUS_CONFIG_TWO = 8'h17;
    // bus_config_one fields
    localparam int B1_ROM_WIDTH = 7;
    localparam int B1_IO_FOLLOWUP = 5;
    localparam int B1_LOCAL_CLAIM = 4;
    localparam int B1_IO_CMD_DLY = 2;
    localparam int B1_MEM16_CMD_DLY = 0;
    localparam logic [7:0] B1_RESET = 8'h20;
    localparam logic [7:0] B1_WMASK = 8'hB5;
    // bus_config_two fields
    localparam int B2_CPU_CLK_GATE_N = 7;
    localparam int B2_DMA_AUTOGATE_N = 6;
    localparam int B2_SLOT16_WAIT = 2;
    localparam int B2_SLOT8_WAIT = 0;
    localparam logic [7:0] B2_RESET = 8'hC0;
    localparam logic [7:0] B2_WMASK = 8'hC5;
    // Wait-state counts in bus clocks and the refresh row step
    localparam logic [3:0] WS16_BASE = 4'h0;
    localparam logic [3:0] WS8_BASE = 4'h4;
    localparam logic [3:0] CMD_DLY_ONE = 4'h1;
    localparam logic [3:0] REFRESH_LEN = 4'h3;
    localparam logic [3:0] DMA_LEN = 4'h3;
    localparam logic [3:0] ROW_STEP = 4'h1;
    // Cycle kinds and controller states
    typedef enum logic [1:0] {
        ISC_CYC_IO = 2'b00,
        ISC_CYC_MEM = 2'b01,
        ISC_CYC_SMEM = 2'b10
    } isc_kind_t;
    typedef enum logic [2:0] {
        ISC_IDLE = 3'b000,
        ISC_ADDR = 3'b001,
        ISC_CMD = 3'b010,
        ISC_REFRESH = 3'b011,
        ISC_DMA = 3'b100,
        ISC_MASTER = 3'b101
    } isc_state_t;
endpackage : isc_pkg

// ### hdl/isc_sync.sv
// Two-flop synchroniser for slot pins
module isc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : isc_sync

// ### hdl/isc_slot_ctrl.sv
// Slot bus cycle control with the two indexed bus configuration registers
module isc_slot_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Indexed configuration port
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Strap
    input wire logic strap_address_line,
    // Internal cycle requests
    input wire logic cpu_req,
    input wire logic [1:0] cpu_kind,
    input wire logic cpu_write,
    input wire logic [23:0] cpu_addr,
    input wire logic refresh_req,
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [23:0] dma_addr,
    input wire logic dma_ack,
    output logic cyc_done,
    output logic cyc_ignored,
    output logic slow_cycle,
    // Slot pins
    input wire logic memcs16_n,
    input wire logic iocs16_n,
    input wire logic iochrdy,
    input wire logic zero_wait_request_n,
    input wire logic master_n,
    input wire logic local_bus_claim_n,
    output logic ior_n,
    output logic iow_n,
    output logic memr_n,
    output logic memw_n,
    output logic smemr_n,
    output logic smemw_n,
    output logic bale,
    output logic aen,
    output logic refresh_n,
    output logic [23:0] sa_out,
    output logic bus_oe_n,
    // ROM, clock and DMA power
    output logic rom_16bit,
    input wire logic sleep_active,
    input wire logic [1:0] dma_drq_any,
    input wire logic [1:0] dma_dack_any,
    output logic cpu_clk_hold_low,
    output logic [1:0] dma_clk_en
);
    // Synchronised pins
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    // Active-low pins enter inverted, so a cleared synchroniser reads as idle after reset
    assign pin_raw = {~local_bus_claim_n, ~master_n, ~zero_wait_request_n, iochrdy, ~iocs16_n, ~memcs16_n};
    isc_sync #(.W(6)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(pin_raw),
        .dout(pin_s)
    );
    wire mcs16_s = pin_s[0];
    wire ics16_s = pin_s[1];
    wire rdy_s = pin_s[2];
    wire zws_s = pin_s[3];
    wire master_s = pin_s[4];
    wire claim_s = pin_s[5];

    // Configuration registers
    logic [7:0] cfg1_r;
    logic [7:0] cfg2_r;
    logic strap_done_r;
    wire wr_one = cfg_wr && (cfg_index == isc_pkg::IDX_BUS_CONFIG_ONE);
    wire wr_two = cfg_wr && (cfg_index == isc_pkg::IDX_BUS_CONFIG_TWO);
    wire [7:0] cfg1_nxt = (cfg_wdata & isc_pkg::B1_WMASK) | (cfg1_r & ~isc_pkg::B1_WMASK);
    wire [7:0] cfg2_nxt = (cfg_wdata & isc_pkg::B2_WMASK) | (cfg2_r & ~isc_pkg::B2_WMASK);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg1_r <= isc_pkg::B1_RESET;
            cfg2_r <= isc_pkg::B2_RESET;
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
            if (!strap_done_r) begin
                cfg1_r[isc_pkg::B1_ROM_WIDTH] <= strap_address_line;
            end else if (wr_one) begin
                cfg1_r <= cfg1_nxt;
            end
            if (wr_two) begin
                cfg2_r <= cfg2_nxt;
            end
        end
    end

    wire [7:0] rd_nxt = (cfg_index == isc_pkg::IDX_BUS_CONFIG_ONE) ? cfg1_r :
                        (cfg_index == isc_pkg::IDX_BUS_CONFIG_TWO) ? cfg2_r : 8'h00;

    // Cycle state
    isc_pkg::isc_state_t st_r;
    isc_pkg::isc_state_t st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [1:0] kind_r;
    logic write_r;
    logic last_io_r;
    logic [7:0] row_r;
    logic [7:0] lat1_r;
    logic [7:0] lat2_r;

    // Wait length from the settings latched at cycle start
    wire is_io = (kind_r == isc_pkg::ISC_CYC_IO);
    wire wide = is_io ? ics16_s : mcs16_s;
    wire [3:0] base_ws = wide ? (lat2_r[isc_pkg::B2_SLOT16_WAIT] ? 4'h1 : isc_pkg::WS16_BASE)
                              : (isc_pkg::WS8_BASE + {3'h0, lat2_r[isc_pkg::B2_SLOT8_WAIT]});
    wire add_io_dly = lat1_r[isc_pkg::B1_IO_CMD_DLY] && (is_io || !wide);
    wire add_m16_dly = lat1_r[isc_pkg::B1_MEM16_CMD_DLY] && !is_io && wide;
    wire [3:0] cmd_len = base_ws + ((add_io_dly || add_m16_dly) ? isc_pkg::CMD_DLY_ONE : 4'h0);
    wire cmd_end = (zws_s || cnt_r >= cmd_len) && rdy_s;
    wire claim_drop = lat1_r[isc_pkg::B1_LOCAL_CLAIM] && claim_s;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 4'h1;
        unique case (st_r)
            isc_pkg::ISC_IDLE: begin
                cnt_nxt = 4'h0;
                if (dma_ack && master_s) begin
                    st_nxt = isc_pkg::ISC_MASTER;
                end else if (refresh_req) begin
                    st_nxt = isc_pkg::ISC_REFRESH;
                end else if (dma_req) begin
                    st_nxt = isc_pkg::ISC_DMA;
                end else if (cpu_req) begin
                    st_nxt = isc_pkg::ISC_ADDR;
                end
            end
            isc_pkg::ISC_ADDR: begin
                cnt_nxt = 4'h0;
                st_nxt = claim_drop ? isc_pkg::ISC_IDLE : isc_pkg::ISC_CMD;
            end
            isc_pkg::ISC_CMD: begin
                if (claim_drop || cmd_end) begin
                    st_nxt = isc_pkg::ISC_IDLE;
                end
            end
            isc_pkg::ISC_REFRESH: begin
                if (cnt_r >= isc_pkg::REFRESH_LEN && rdy_s) begin
                    st_nxt = isc_pkg::ISC_IDLE;
                end
            end
            isc_pkg::ISC_DMA: begin
                if (cnt_r >= isc_pkg::DMA_LEN && rdy_s) begin
                    st_nxt = isc_pkg::ISC_IDLE;
                end
            end
            isc_pkg::ISC_MASTER: begin
                if (!master_s) begin
                    st_nxt = isc_pkg::ISC_IDLE;
                end
            end
            default: st_nxt = isc_pkg::ISC_IDLE;
        endcase
    end

    wire start_cpu = (st_r == isc_pkg::ISC_IDLE) && (st_nxt == isc_pkg::ISC_ADDR);
    wire start_any = (st_r == isc_pkg::ISC_IDLE) && (st_nxt != isc_pkg::ISC_IDLE);
    wire in_cmd = (st_nxt == isc_pkg::ISC_CMD);
    wire in_ref = (st_nxt == isc_pkg::ISC_REFRESH);
    wire in_dma = (st_nxt == isc_pkg::ISC_DMA);
    wire rd_cmd = in_cmd && !write_r;
    wire wr_cmd = in_cmd && write_r;
    wire dma_io_rd = in_dma && dma_write;
    wire dma_mem_rd = in_dma && !dma_write;
    wire ending = (st_r != isc_pkg::ISC_IDLE) && (st_nxt == isc_pkg::ISC_IDLE);
    wire [1:0] dma_run = dma_drq_any | dma_dack_any;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= isc_pkg::ISC_IDLE;
            cnt_r <= 4'h0;
            kind_r <= 2'b00;
            write_r <= 1'b0;
            last_io_r <= 1'b0;
            row_r <= 8'h00;
            lat1_r <= isc_pkg::B1_RESET;
            lat2_r <= isc_pkg::B2_RESET;
            ior_n <= 1'b1;
            iow_n <= 1'b1;
            memr_n <= 1'b1;
            memw_n <= 1'b1;
            smemr_n <= 1'b1;
            smemw_n <= 1'b1;
            bale <= 1'b0;
            aen <= 1'b0;
            refresh_n <= 1'b1;
            sa_out <= 24'h000000;
            bus_oe_n <= 1'b1;
            cyc_done <= 1'b0;
            cyc_ignored <= 1'b0;
            slow_cycle <= 1'b0;
            cfg_rdata <= 8'h00;
            rom_16bit <= 1'b0;
            cpu_clk_hold_low <= 1'b0;
            dma_clk_en <= 2'b11;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            cfg_rdata <= rd_nxt;
            if (start_any) begin
                lat1_r <= cfg1_r;
                lat2_r <= cfg2_r;
            end
            if (start_cpu) begin
                kind_r <= cpu_kind;
                write_r <= cpu_write;
                sa_out <= cpu_addr;
                slow_cycle <= cfg1_r[isc_pkg::B1_IO_FOLLOWUP] && last_io_r
                              && (cpu_kind != isc_pkg::ISC_CYC_IO);
                last_io_r <= (cpu_kind == isc_pkg::ISC_CYC_IO);
            end else if (st_nxt == isc_pkg::ISC_REFRESH && st_r == isc_pkg::ISC_IDLE) begin
                sa_out <= {16'h0000, row_r};
                row_r <= row_r + {4'h0, isc_pkg::ROW_STEP};
            end else if (st_nxt == isc_pkg::ISC_DMA && st_r == isc_pkg::ISC_IDLE) begin
                sa_out <= dma_addr;
            end
            // Address latch strobe: pulse for processor, held for refresh and DMA
            bale <= (st_nxt == isc_pkg::ISC_ADDR) || in_ref || in_dma;
            ior_n <= !((rd_cmd && kind_r == isc_pkg::ISC_CYC_IO) || dma_io_rd);
            iow_n <= !((wr_cmd && kind_r == isc_pkg::ISC_CYC_IO) || dma_mem_rd);
            memr_n <= !((rd_cmd && kind_r == isc_pkg::ISC_CYC_MEM) || in_ref || dma_mem_rd);
            memw_n <= !((wr_cmd && kind_r == isc_pkg::ISC_CYC_MEM) || dma_io_rd);
            smemr_n <= !((rd_cmd && kind_r == isc_pkg::ISC_CYC_SMEM) || in_ref);
            smemw_n <= !(wr_cmd && kind_r == isc_pkg::ISC_CYC_SMEM);
            refresh_n <= !in_ref;
            aen <= in_dma;
            bus_oe_n <= (st_nxt == isc_pkg::ISC_MASTER) || (st_nxt == isc_pkg::ISC_IDLE);
            cyc_done <= ending && !claim_drop;
            cyc_ignored <= ending && claim_drop && (st_r == isc_pkg::ISC_ADDR || st_r == isc_pkg::ISC_CMD);
            rom_16bit <= cfg1_r[isc_pkg::B1_ROM_WIDTH];
            cpu_clk_hold_low <= sleep_active && !cfg2_r[isc_pkg::B2_CPU_CLK_GATE_N];
            dma_clk_en <= cfg2_r[isc_pkg::B2_DMA_AUTOGATE_N] ? 2'b11 : dma_run;
        end
    end

    // Checks
    chk_refresh_bale: assert property (@(posedge clk) disable iff (sys_rst)
        !refresh_n |-> bale) else $error("bale low during refresh");
    chk_refresh_pair: assert property (@(posedge clk) disable iff (sys_rst)
        !refresh_n |-> !memr_n) else $error("refresh without memory read");
    chk_dma_aen: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_DMA) |-> aen && bale) else $error("dma without aen or bale");
    chk_refresh_stretch: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_REFRESH && !rdy_s) |=> !refresh_n) else $error("refresh ended while not ready");
    chk_dma_stretch: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_DMA && !rdy_s) |=> aen) else $error("dma ended while not ready");
    chk_master_release: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_MASTER) |-> bus_oe_n) else $error("bus driven during master");
    chk_slot8_waits: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_CMD && !wide && !zws_s && !claim_drop && cnt_r < isc_pkg::WS8_BASE)
        |=> st_r == isc_pkg::ISC_CMD)
        else $error("8-bit cycle ended early");
    chk_claim_drop: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_CMD && claim_drop) |=> st_r == isc_pkg::ISC_IDLE) else $error("claimed cycle kept");
    chk_dma_clock: assert property (@(posedge clk) disable iff (sys_rst)
        $past(cfg2_r[isc_pkg::B2_DMA_AUTOGATE_N]) |-> dma_clk_en == 2'b11) else $error("dma clock gated");

    // Processor cycle shape
    chk_cpu_bale_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_ADDR) |-> bale)
        else $error("no latch strobe in address phase");
    chk_bale_drop: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_CMD) |-> !bale)
        else $error("latch strobe held into command");
    chk_cmd_exclusive: assert property (@(posedge clk) disable iff (sys_rst)
        !(!ior_n && !iow_n) && !(!memr_n && !memw_n) && !(!smemr_n && !smemw_n))
        else $error("read and write strobes together");
    chk_slow_after_io: assert property (@(posedge clk) disable iff (sys_rst)
        slow_cycle |-> kind_r != isc_pkg::ISC_CYC_IO)
        else $error("slow flag on an io cycle");

    // Refresh, DMA and master
    chk_refresh_row: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_IDLE && st_nxt == isc_pkg::ISC_REFRESH) |=> sa_out[7:0] == $past(row_r))
        else $error("refresh row not driven");
    chk_aen_dma_only: assert property (@(posedge clk) disable iff (sys_rst)
        aen |-> st_r == isc_pkg::ISC_DMA)
        else $error("aen outside dma");
    chk_master_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == isc_pkg::ISC_MASTER) |-> ior_n && iow_n && memr_n && memw_n && smemr_n && smemw_n)
        else $error("command driven during master");

    // Configuration outputs; one clock behind the register
    chk_rom_width: assert property (@(posedge clk) disable iff (sys_rst)
        rom_16bit == $past(cfg1_r[isc_pkg::B1_ROM_WIDTH]))
        else $error("rom width not following bit");
    chk_clock_hold: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_clk_hold_low |-> !$past(cfg2_r[isc_pkg::B2_CPU_CLK_GATE_N]))
        else $error("clock held with gate bit high");
    chk_dma_autogate: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(cfg2_r[isc_pkg::B2_DMA_AUTOGATE_N]) |-> dma_clk_en == $past(dma_run))
        else $error("dma clock not following requests");

    cov_cpu: cover property (@(posedge clk) disable iff (sys_rst) cyc_done && !aen);
    cov_refresh: cover property (@(posedge clk) disable iff (sys_rst) !refresh_n && !iochrdy);
    cov_master: cover property (@(posedge clk) disable iff (sys_rst) st_r == isc_pkg::ISC_MASTER);
    cov_claim: cover property (@(posedge clk) disable iff (sys_rst) cyc_ignored);
    cov_dma: cover property (@(posedge clk) disable iff (sys_rst) aen && !iochrdy);
endmodule : isc_slot_ctrl

// ### sim/isc_card.sv
// Slot card model: width, ready stall, zero-wait request and bus master pin
module isc_card (
    // Clock
    input wire logic clk,
    // Bench controls
    input wire logic wide,
    input wire logic zws,
    input wire logic [3:0] stall,
    input wire logic mstr,
    input wire logic dma_ack,
    // Slot pins
    input wire logic cmd_n,
    output logic cs16_n,
    output logic iochrdy,
    output logic zero_wait_request_n,
    output logic master_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt = 4'h0;
    logic cmd_d = 1'b1;
    logic start;
    assign start = cmd_d && !cmd_n && (stall != 4'h0);
    // Width held for the whole cycle, so always ahead of the last wait
    assign cs16_n = ~wide;
    // Pull-up line: inactive outside commands
    assign zero_wait_request_n = ~(zws & ~cmd_n);
    // Ready low from command start for stall clocks
    assign iochrdy = (cnt == 4'h0) && !start;
    // Master pin only once acknowledged
    assign master_n = ~(mstr & dma_ack);
    always @(posedge clk) begin
        cmd_d <= cmd_n;
        if (start) begin
            cnt <= stall - 4'h1;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : isc_card

// ### sim/isc_slot_ctrl_bench.sv
// Bench: slot cycle control with a card model on the slot pins
module isc_slot_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cpu_req = 1'b0, refresh_req = 1'b0, dma_req = 1'b0;
    logic dma_ack = 1'b0, claim_n = 1'b1, sleep_active = 1'b0, wide = 1'b0, zws = 1'b0, mstr = 1'b0;
    logic cpu_write = 1'b0, dma_write = 1'b0;
    logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00;
    logic [1:0] cpu_kind = 2'h0, drq = 2'h0, dack = 2'h0;
    logic [3:0] stall = 4'h0;
    logic [23:0] cpu_addr = 24'h0A5301, dma_addr = 24'h05A7C2;
    wire logic [7:0] cfg_rdata;
    wire logic [23:0] sa_out;
    wire logic [1:0] dma_clk_en;
    wire logic cyc_done, cyc_ignored, slow_cycle, ior_n, iow_n, memr_n, memw_n, smemr_n, smemw_n, bale, aen;
    wire logic refresh_n, bus_oe_n, rom_16bit, cpu_clk_hold_low, cs16_n, iochrdy, zw_n, master_n, cmd_n;
    int cycles = 0, fails = 0, cmp_count = 0, base8 = 0;
    assign cmd_n = ior_n & iow_n & memr_n & memw_n & smemr_n & smemw_n;
    isc_slot_ctrl u_isc_slot_ctrl (.clk, .sys_rst, .cfg_wr, .cfg_index, .cfg_wdata, .cfg_rdata,
        .strap_address_line(1'b1), .cpu_req, .cpu_kind, .cpu_write, .cpu_addr, .refresh_req,
        .dma_req, .dma_write, .dma_addr, .dma_ack, .cyc_done, .cyc_ignored, .slow_cycle,
        .memcs16_n(cs16_n), .iocs16_n(cs16_n), .iochrdy, .zero_wait_request_n(zw_n), .master_n,
        .local_bus_claim_n(claim_n), .ior_n, .iow_n, .memr_n, .memw_n, .smemr_n, .smemw_n, .bale, .aen,
        .refresh_n, .sa_out, .bus_oe_n, .rom_16bit, .sleep_active, .dma_drq_any(drq),
        .dma_dack_any(dack), .cpu_clk_hold_low, .dma_clk_en);
    isc_card u_isc_card (.clk, .wide, .zws, .stall, .mstr, .dma_ack, .cmd_n, .cs16_n, .iochrdy,
        .zero_wait_request_n(zw_n), .master_n);
    initial forever #20 clk = ~clk;
    // Ceiling far above the expected run of about five hundred clocks
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic fin(input string nm);
        $display("test %s done", nm);
    endtask : fin
    // Callers keep reserved bits as read back, which is zero, except the 8'hFF writes in t_regs
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        cfg_index <= i;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr
    task automatic rdk(input logic [7:0] i, input logic [7:0] e);
        @(posedge clk);
        cfg_index <= i;
        repeat (3) @(negedge clk);
        chk("cfg_rdata", cfg_rdata, e);
    endtask : rdk
    task automatic card(input logic w, input logic z, input logic [3:0] s);
        @(posedge clk);
        wide <= w;
        zws <= z;
        stall <= s;
    endtask : card
    // One cycle of kind w (0 cpu, 1 refresh, 2 dma); length in command clocks
    task automatic run(input int w, input logic [1:0] k, output int len, output logic f, output logic [23:0] a);
        int n;
        len = 0;
        n = 0;
        f = (w != 0);
        @(posedge clk);
        cpu_kind <= k;
        if (w == 0) cpu_req <= 1'b1;
        else if (w == 1) refresh_req <= 1'b1;
        else dma_req <= 1'b1;
        while (cmd_n && n < 40) begin
            @(negedge clk);
            n++;
        end
        a = sa_out;
        while (!cmd_n && n < 120) begin
            len++;
            if (w == 0) f = f | slow_cycle;
            if (w == 1) f = f & bale & ~refresh_n & ~memr_n;
            if (w == 2) f = f & bale & aen;
            if (len == 1) begin
                @(posedge clk);
                cpu_req <= 1'b0;
                refresh_req <= 1'b0;
                dma_req <= 1'b0;
            end
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
    endtask : run
    task automatic t_regs();
        rdk(8'h16, 8'hA0);
        rdk(8'h17, 8'hC0);
        rdk(8'h18, 8'h00);
        wr(8'h16, 8'hFF);
        rdk(8'h16, 8'hB5);
        chk("rom_16bit", rom_16bit, 1);
        wr(8'h16, 8'h20);
        chk("rom_16bit", rom_16bit, 0);
        wr(8'h17, 8'hFF);
        rdk(8'h17, 8'hC5);
        wr(8'h17, 8'hC0);
        wr(8'h16, 8'hA0);
        fin("regs");
    endtask : t_regs
    task automatic t_io8();
        int l;
        logic f;
        logic [23:0] a;
        run(0, 2'b00, base8, f, a);
        chk("sa_out", a, cpu_addr);
        chk("io8_min", base8 >= 5, 1);
        wr(8'h17, 8'hC1);
        run(0, 2'b00, l, f, a);
        chk("io8_ws5", l, base8 + 1);
        wr(8'h17, 8'hC0);
        wr(8'h16, 8'hA4);
        run(0, 2'b00, l, f, a);
        chk("io8_dly", l, base8 + 1);
        wr(8'h16, 8'hA0);
        card(0, 0, 4'hC);
        run(0, 2'b00, l, f, a);
        chk("io8_stall", l > base8 + 4, 1);
        card(0, 1, 4'h0);
        run(0, 2'b00, l, f, a);
        chk("io8_zws", l < base8, 1);
        card(0, 0, 4'h0);
        fin("io8");
    endtask : t_io8
    task automatic t_mem16();
        int b, l;
        logic f;
        logic [23:0] a;
        card(1, 0, 4'h0);
        run(0, 2'b01, b, f, a);
        run(0, 2'b01, b, f, a);
        chk("mem16_len", b < base8, 1);
        wr(8'h17, 8'hC4);
        run(0, 2'b01, l, f, a);
        chk("mem16_ws1", l, b + 1);
        wr(8'h17, 8'hC0);
        wr(8'h16, 8'hA1);
        run(0, 2'b01, l, f, a);
        chk("mem16_dly", l, b + 1);
        wr(8'h16, 8'hA0);
        card(0, 0, 4'h0);
        fin("mem16");
    endtask : t_mem16
    task automatic t_refresh();
        int l, l2;
        logic f;
        logic [23:0] a, a2;
        run(1, 2'b00, l, f, a);
        chk("refresh_pins", f, 1);
        chk("refresh_len", l >= 4, 1);
        run(1, 2'b00, l2, f, a2);
        chk("refresh_row", a2[7:0], a[7:0] + 8'(isc_pkg::ROW_STEP));
        card(0, 0, 4'hC);
        run(1, 2'b00, l2, f, a2);
        chk("refresh_stall", l2 > l + 6, 1);
        chk("refresh_pins", f, 1);
        card(0, 0, 4'h0);
        fin("refresh");
    endtask : t_refresh
    task automatic t_dma();
        int l, l2;
        logic f;
        logic [23:0] a;
        run(2, 2'b00, l, f, a);
        chk("dma_bale_aen", f, 1);
        chk("dma_addr", a, dma_addr);
        chk("dma_len", l >= 4, 1);
        card(0, 0, 4'hC);
        run(2, 2'b00, l2, f, a);
        chk("dma_stall", l2 > l + 6, 1);
        card(0, 0, 4'h0);
        fin("dma");
    endtask : t_dma
    task automatic t_strobes();
        int n;
        @(posedge clk);
        cpu_write <= 1'b1;
        cpu_kind <= 2'b10;
        cpu_req <= 1'b1;
        for (n = 0; n < 20 && cmd_n; n++) @(negedge clk);
        chk("smemw_n", smemw_n, 0);
        chk("memw_n", memw_n, 1);
        @(posedge clk);
        cpu_req <= 1'b0;
        repeat (10) @(negedge clk);
        @(posedge clk);
        cpu_write <= 1'b0;
        dma_write <= 1'b1;
        dma_req <= 1'b1;
        for (n = 0; n < 20 && cmd_n; n++) @(negedge clk);
        chk("ior_n", ior_n, 0);
        chk("memw_n", memw_n, 0);
        @(posedge clk);
        dma_req <= 1'b0;
        repeat (8) @(negedge clk);
        @(posedge clk);
        dma_write <= 1'b0;
        fin("strobes");
    endtask : t_strobes
    task automatic t_master();
        @(posedge clk);
        mstr <= 1'b1;
        dma_ack <= 1'b1;
        repeat (6) @(negedge clk);
        @(posedge clk);
        cpu_req <= 1'b1;
        repeat (6) @(negedge clk);
        chk("bus_oe_n", bus_oe_n, 1);
        chk("cmd_n", cmd_n, 1);
        @(posedge clk);
        mstr <= 1'b0;
        dma_ack <= 1'b0;
        repeat (6) @(negedge clk);
        chk("cmd_n", cmd_n, 0);
        chk("bus_oe_n", bus_oe_n, 0);
        @(posedge clk);
        cpu_req <= 1'b0;
        repeat (8) @(negedge clk);
        fin("master");
    endtask : t_master
    task automatic t_claim();
        int l;
        logic f, seen;
        logic [23:0] a;
        seen = 1'b0;
        wr(8'h16, 8'hB0);
        @(posedge clk);
        claim_n <= 1'b0;
        cpu_req <= 1'b1;
        for (int n = 0; n < 20 && seen !== 1'b1; n++) begin
            @(negedge clk);
            seen = cyc_ignored;
        end
        @(posedge clk);
        cpu_req <= 1'b0;
        repeat (8) @(negedge clk);
        chk("cyc_ignored", seen, 1);
        wr(8'h16, 8'hA0);
        run(0, 2'b00, l, f, a);
        chk("claim_off", l, base8);
        @(posedge clk);
        claim_n <= 1'b1;
        fin("claim");
    endtask : t_claim
    task automatic t_slow();
        int l;
        logic f;
        logic [23:0] a;
        run(0, 2'b00, l, f, a);
        run(0, 2'b01, l, f, a);
        chk("slow_cycle", f, 1);
        run(0, 2'b01, l, f, a);
        chk("slow_cycle", f, 0);
        wr(8'h16, 8'h80);
        run(0, 2'b00, l, f, a);
        run(0, 2'b01, l, f, a);
        chk("slow_cycle", f, 0);
        wr(8'h16, 8'hA0);
        fin("slow");
    endtask : t_slow
    task automatic t_power();
        @(posedge clk);
        sleep_active <= 1'b1;
        wr(8'h17, 8'h40);
        chk("cpu_clk_hold_low", cpu_clk_hold_low, 1);
        wr(8'h17, 8'hC0);
        chk("cpu_clk_hold_low", cpu_clk_hold_low, 0);
        wr(8'h17, 8'h80);
        chk("dma_clk_en", dma_clk_en, 2'b00);
        @(posedge clk);
        drq <= 2'b01;
        repeat (4) @(negedge clk);
        chk("dma_clk_en", dma_clk_en, 2'b01);
        @(posedge clk);
        drq <= 2'b00;
        dack <= 2'b10;
        repeat (4) @(negedge clk);
        chk("dma_clk_en", dma_clk_en, 2'b10);
        @(posedge clk);
        dack <= 2'b00;
        sleep_active <= 1'b0;
        wr(8'h17, 8'hC0);
        chk("dma_clk_en", dma_clk_en, 2'b11);
        fin("power");
    endtask : t_power
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_regs();
        t_io8();
        t_mem16();
        t_refresh();
        t_dma();
        t_strobes();
        t_master();
        t_claim();
        t_slow();
        t_power();
        summarize();
    end
endmodule : isc_slot_ctrl_bench
